// *** verilog/paa_params.svh ***
// Constants of the path auto AIS insertion control block
`ifndef PAA_PARAMS_SVH
`define PAA_PARAMS_SVH

// Register indices; byte address is four times the index
`define PAA_EN_IDX 32'h0000_11C3
`define PAA_STAT_IDX 32'h0000_11C4
`define PAA_EN_ADDR (`PAA_EN_IDX << 2)
`define PAA_STAT_ADDR (`PAA_STAT_IDX << 2)

// Enable register field positions
`define PAA_BIT_LOP 7
`define PAA_BIT_PLM 5
`define PAA_BIT_UNEQ 3
`define PAA_BIT_TIM 2
`define PAA_BIT_AIS 1

// Reset value and writable bits of the enable register
`define PAA_EN_RESET 8'h00
`define PAA_EN_WMASK 8'hAE

// Default channel count and its upper limit
`define PAA_NCH_DEF 3
`define PAA_NCH_MAX 8

`endif

// *** verilog/paa_pkg.sv ***
// Types of the path auto AIS insertion control block
`default_nettype none
package paa_pkg;

  // Path defects declared by one channel's receive path processor
  typedef struct packed {
    logic lop;
    logic plm;
    logic uneq;
    logic tim;
    logic ais;
  } paa_defect_t;

  // APB request fields travelling together
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] strb;
  } paa_apb_req_t;

endpackage
`default_nettype wire

// *** verilog/paa_ctrl.sv ***
// APB-controlled automatic path AIS insertion request logic
`include "paa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module paa_ctrl
  import paa_pkg::*;
#(
  parameter int NCH = `PAA_NCH_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Per-channel defects from the receive path processors
  input wire paa_defect_t [NCH-1:0] defect,
  // Per-channel AIS insertion requests to the transmit path processors
  output logic [NCH-1:0] ais_req
);

  // Refuse channel counts below 1 or above PAA_NCH_MAX
  if (NCH < 1 || NCH > `PAA_NCH_MAX) begin : g_bad_nch
    $error("paa_ctrl: NCH out of range");
  end

  // Each defect's enable bit must be writable, or that defect could never insert AIS
  if ((`PAA_EN_WMASK & (8'h01 << `PAA_BIT_LOP)) == 8'h00) begin : g_bad_lop
    $error("paa_ctrl: loss of pointer enable not writable");
  end
  if ((`PAA_EN_WMASK & (8'h01 << `PAA_BIT_PLM)) == 8'h00) begin : g_bad_plm
    $error("paa_ctrl: label mismatch enable not writable");
  end
  if ((`PAA_EN_WMASK & (8'h01 << `PAA_BIT_UNEQ)) == 8'h00) begin : g_bad_uneq
    $error("paa_ctrl: unequipped enable not writable");
  end
  if ((`PAA_EN_WMASK & (8'h01 << `PAA_BIT_TIM)) == 8'h00) begin : g_bad_tim
    $error("paa_ctrl: trace mismatch enable not writable");
  end
  if ((`PAA_EN_WMASK & (8'h01 << `PAA_BIT_AIS)) == 8'h00) begin : g_bad_ais
    $error("paa_ctrl: incoming AIS enable not writable");
  end

  // Registers take whole aligned words; a misaligned address could never be hit
  if (((`PAA_EN_ADDR | `PAA_STAT_ADDR) & 32'h0000_0003) != 32'h0000_0000) begin : g_bad_addr
    $error("paa_ctrl: register address not word aligned");
  end

  // Defects of one channel with every disabled kind masked off
  function automatic paa_defect_t mask_of(input paa_defect_t d, input logic [7:0] en);
    paa_defect_t m;
    m.lop = en[`PAA_BIT_LOP] & d.lop;
    m.plm = en[`PAA_BIT_PLM] & d.plm;
    m.uneq = en[`PAA_BIT_UNEQ] & d.uneq;
    m.tim = en[`PAA_BIT_TIM] & d.tim;
    m.ais = en[`PAA_BIT_AIS] & d.ais;
    mask_of = m;
  endfunction

  // Request of one channel from its defects and the shared enables
  function automatic logic req_of(input paa_defect_t d, input logic [7:0] en);
    req_of = |mask_of(d, en);
  endfunction

  // Enable read word: stored bits in the low byte, zero above
  function automatic logic [31:0] en_word(input logic [7:0] en);
    en_word = {24'h00_0000, en};
  endfunction

  // Status word: one request bit per channel, zero above the last channel
  function automatic logic [31:0] stat_word(input logic [NCH-1:0] r);
    stat_word = 32'h0000_0000;
    stat_word[NCH-1:0] = r;
  endfunction

  paa_apb_req_t req;
  logic [7:0] en_ff;
  logic [7:0] nxt_en;
  logic [NCH-1:0] req_ff;
  logic [NCH-1:0] nxt_req;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic err_ff;
  logic nxt_err;
  logic hit_en;
  logic hit_stat;
  logic setup;
  logic wr_access;

  // Bundle the bus request
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};

  // Address decode and phase qualifiers
  assign hit_en = (req.addr == `PAA_EN_ADDR);
  assign hit_stat = (req.addr == `PAA_STAT_ADDR);
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & req.write;

  // Zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = rdata_ff;
  assign pslverr = err_ff;
  assign ais_req = req_ff;

  // Enable register write; unused bits are never stored so they read zero
  always_comb begin
    nxt_en = en_ff;
    if (wr_access && hit_en && req.strb[0]) begin
      nxt_en = req.wdata[7:0] & `PAA_EN_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= `PAA_EN_RESET;
    end else begin
      en_ff <= nxt_en;
    end
  end

  // Read data and error prepared in the setup cycle so they come from flops
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = ~(hit_en | hit_stat);
      if (!req.write && hit_en) begin
        nxt_rdata = en_word(en_ff);
      end else if (!req.write && hit_stat) begin
        nxt_rdata = stat_word(req_ff);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  // Per-channel request; a channel sees only its own defects
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      nxt_req[c] = req_of(defect[c], en_ff);
    end
  end

  // Registered so the transmit side sees a glitch-free level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // Checks on each channel's request
  for (genvar c = 0; c < NCH; c++) begin : g_chk
    a_lop_insert: assert property (@(posedge pclk) disable iff (!presetn)
      en_ff[`PAA_BIT_LOP] && defect[c].lop |=> ais_req[c])
      else $error("loss of pointer did not request AIS");

    a_plm_insert: assert property (@(posedge pclk) disable iff (!presetn)
      en_ff[`PAA_BIT_PLM] && defect[c].plm |=> ais_req[c])
      else $error("label mismatch did not request AIS");

    a_uneq_insert: assert property (@(posedge pclk) disable iff (!presetn)
      en_ff[`PAA_BIT_UNEQ] && defect[c].uneq |=> ais_req[c])
      else $error("unequipped path did not request AIS");

    a_tim_insert: assert property (@(posedge pclk) disable iff (!presetn)
      en_ff[`PAA_BIT_TIM] && defect[c].tim |=> ais_req[c])
      else $error("trace mismatch did not request AIS");

    a_ais_insert: assert property (@(posedge pclk) disable iff (!presetn)
      en_ff[`PAA_BIT_AIS] && defect[c].ais |=> ais_req[c])
      else $error("incoming AIS did not request AIS");

    a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (en_ff == 8'h00) [*2] |-> !ais_req[c])
      else $error("request raised with all enables clear");

    a_own_channel: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ais_req[c] == req_of($past(defect[c]), $past(en_ff)))
      else $error("request does not follow own channel defects");

    a_clear_drop: assert property (@(posedge pclk) disable iff (!presetn)
      ais_req[c] && !req_of(defect[c], en_ff) |=> !ais_req[c])
      else $error("request held after defects cleared");

    // A channel whose own defects are all masked stays quiet, whatever others do
    a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !req_of(defect[c], en_ff)
      |=> !ais_req[c])
      else $error("request raised by a masked defect");

    // A request only rises for an enabled defect seen one edge earlier
    a_rise_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ais_req[c])
      |-> $past(req_of(defect[c], en_ff)))
      else $error("request rose without an enabled defect");

    // A request stays up while any enabled defect remains declared
    a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
      ais_req[c] && req_of(defect[c], en_ff)
      |=> ais_req[c])
      else $error("request dropped while a defect is declared");
  end

  // Reserved bits of the enable register never become set
  a_en_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && hit_en && pstrb[0] |=> (en_ff & ~`PAA_EN_WMASK) == 8'h00)
    else $error("reserved enable bit stored");

  // Register bus checks; the bench master relies on these timings

  // No wait states: the master never has to stretch an access
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready low during an access");

  // An unmapped address answers with an error and zero data
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !(hit_en || hit_stat)
    |=> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access without error");

  // A mapped address never reports an error
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    setup && (hit_en || hit_stat)
    |=> !pslverr)
    else $error("mapped access reported an error");

  // An error can only appear as the answer to a setup edge
  a_err_only_setup: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pslverr)
    |-> $past(setup))
    else $error("error raised outside an access");

  // Enable read returns the bits stored at the setup edge
  a_en_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_en
    |=> prdata == en_word($past(en_ff)))
    else $error("enable read data wrong");

  // Status read returns the requests as they stood at the setup edge
  a_stat_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_stat
    |=> prdata == stat_word($past(ais_req)))
    else $error("status read data wrong");

  // Writes answer with zero so stale read data is never mistaken for new
  a_write_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && pwrite
    |=> prdata == 32'h0000_0000)
    else $error("write returned nonzero data");

  // Read data and error stand unchanged outside a setup edge
  a_answer_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !setup
    |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer changed outside setup");

  // A strobed enable write stores the masked low byte of the write data
  a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && hit_en && pstrb[0]
    |=> en_ff == ($past(pwdata[7:0]) & `PAA_EN_WMASK))
    else $error("enable write not stored");

  // Anything but a strobed enable write leaves the register alone
  a_en_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && hit_en && pstrb[0])
    |=> $stable(en_ff))
    else $error("enable register changed without a write");

  // Reset clears the request, read data and error outputs and the enable register at once; pready stays high
  a_reset_clear: assert property (@(posedge pclk)
    !presetn
    |-> en_ff == `PAA_EN_RESET && ais_req == '0 && prdata == 32'h0000_0000 && !pslverr)
    else $error("state not cleared in reset");

endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Testbench of the path auto AIS insertion control block
`include "paa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import paa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd, ex;
  logic [3:0] pstrb;
  logic [2:0] ais_req;
  paa_defect_t [2:0] defect, dv;
  int n_errors, n_compared;
  int pos [5] = '{7, 5, 3, 2, 1};
  paa_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .defect(defect), .ais_req(ais_req));
  // Bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; idle edge after it so the next setup never lands in the same step
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    defect = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, `PAA_EN_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0);
    xfer(1'b1, `PAA_EN_ADDR, 32'hFF, 4'hF);
    xfer(1'b0, `PAA_EN_ADDR, 32'h0, 4'hF);
    chk(rd, 32'hAE);
    // Strobe low must leave the register alone
    xfer(1'b1, `PAA_EN_ADDR, 32'h0, 4'hE);
    xfer(1'b0, `PAA_EN_ADDR, 32'h0, 4'hF);
    chk(rd, 32'hAE);
    // Status register is read only: a write is ignored without error
    xfer(1'b1, `PAA_STAT_ADDR, 32'hFF, 4'hF);
    chk({31'h0, er}, 32'h0);
    xfer(1'b0, `PAA_EN_ADDR, 32'h0, 4'hF);
    chk(rd, 32'hAE);
    xfer(1'b0, 32'h0, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    // All enabled: one defect on channel 0, every defect on channel 2
    dv = '0;
    dv[0].lop = 1'b1;
    dv[2] = 5'h1F;
    defect <= dv;
    repeat (3) @(posedge pclk);
    chk({29'h0, ais_req}, 32'h5);
    defect <= '0;
    repeat (3) @(posedge pclk);
    chk({29'h0, ais_req}, 32'h0);
    // One enable at a time against every defect, channels rotated
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, `PAA_EN_ADDR, 32'h1 << pos[k], 4'hF);
      for (int j = 0; j < 5; j++) begin
        dv = '0;
        dv[j % 3] = paa_defect_t'(5'h10 >> j);
        defect <= dv;
        ex = (k == j) ? (32'h1 << (j % 3)) : 32'h0;
        repeat (3) @(posedge pclk);
        chk({29'h0, ais_req}, ex);
        xfer(1'b0, `PAA_STAT_ADDR, 32'h0, 4'hF);
        chk(rd, ex);
      end
    end
    // Mid-run reset clears the enables, so held defects raise nothing
    xfer(1'b1, `PAA_EN_ADDR, 32'hFF, 4'hF);
    defect <= '1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({29'h0, ais_req}, 32'h0);
    xfer(1'b0, `PAA_EN_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
